// ===== pkg/cmd_map.svh
// Address map, field positions, codes and limits of the diag status bank
// How it works
// - Configured list: count plus up to 127 addresses
// - Own CAN node takes entry one, address 0
// - Scan completion sets detected count, max 126
// - Status bit flips on every sync sent
// - Status bit flips on each input refresh
// - Fault flag set while any configured slave's state nonzero, or on bus-off with slaves configured
// - Cycle counter counts only with slaves configured
// - Cycle time reported in ninths of microsecond
// - One 8-bit state per configured slave
// - Codes 0, 1, 2: ok, held, silent
// - Codes 4, 5: startup transfer errors
// - Code 8 while slave boots cleanly
// - Code 11 bus-off, 12 left operational
// - Code 14 when guarding fails to toggle
// - Code 18 started, no host exchange yet
// - Code 20 for wrong transmit object length
// - Code 22 for late timed transmit object
// - Code 23 while objects still missing
// - Code 24 on transmit FIFO overflow
// - Code 40 for missed type-1 object
`ifndef CMD_MAP_SVH
`define CMD_MAP_SVH

`define CMD_MAX_CFG      127
`define CMD_MAX_DET      126
`define CMD_EXT_ENTRIES  8'h14
`define CMD_OWN_NODE_ADR 16'h0000

// Address regions, selected by adr_i[11:9]
`define CMD_RGN_SCALAR   3'h0
`define CMD_RGN_CFG      3'h1
`define CMD_RGN_DET      3'h2
`define CMD_RGN_NS       3'h3

// Word indices inside the scalar region, adr_i[8:2]
`define CMD_W_CFG_CNT    7'h00
`define CMD_W_DET_CNT    7'h01
`define CMD_W_EXT_CNT    7'h02
`define CMD_W_DIAG       7'h03
`define CMD_W_CYC_CNT    7'h04
`define CMD_W_STAT_CNT   7'h05
`define CMD_W_CYC_TIME   7'h06
`define CMD_W_NS_CNT     7'h07

// Bit positions in the diag flag word
`define CMD_B_SYNC_TGL   0
`define CMD_B_DEV_DIAG   1
`define CMD_B_SYNC_ERR   2
`define CMD_B_IN_TGL     3
`define CMD_B_FAULT      4

// Node state codes
`define CMD_NS_OK        8'h00
`define CMD_NS_HELD      8'h01
`define CMD_NS_SILENT    8'h02
`define CMD_NS_UP_LEN    8'h04
`define CMD_NS_UP_VAL    8'h05
`define CMD_NS_BOOT      8'h08
`define CMD_NS_BUS_OFF   8'h0B
`define CMD_NS_LEFT_OP   8'h0C
`define CMD_NS_GUARD     8'h0E
`define CMD_NS_NO_XCHG   8'h12
`define CMD_NS_TX_LEN    8'h14
`define CMD_NS_TX_LATE   8'h16
`define CMD_NS_TX_MISS   8'h17
`define CMD_NS_FIFO_OVF  8'h18
`define CMD_NS_TYPE1     8'h28

`endif

// ===== pkg/cmd_pkg.sv
// Types shared by the diag status bank and its users
`include "cmd_map.svh"
package cmd_pkg;

  // Node state codes of one slave
  typedef enum logic [7:0] {
    CMD_NS_OK_E      = `CMD_NS_OK,
    CMD_NS_HELD_E    = `CMD_NS_HELD,
    CMD_NS_SILENT_E  = `CMD_NS_SILENT,
    CMD_NS_UP_LEN_E  = `CMD_NS_UP_LEN,
    CMD_NS_UP_VAL_E  = `CMD_NS_UP_VAL,
    CMD_NS_BOOT_E    = `CMD_NS_BOOT,
    CMD_NS_BUS_OFF_E = `CMD_NS_BUS_OFF,
    CMD_NS_LEFT_OP_E = `CMD_NS_LEFT_OP,
    CMD_NS_GUARD_E   = `CMD_NS_GUARD,
    CMD_NS_NO_XCHG_E = `CMD_NS_NO_XCHG,
    CMD_NS_TX_LEN_E  = `CMD_NS_TX_LEN,
    CMD_NS_TX_LATE_E = `CMD_NS_TX_LATE,
    CMD_NS_TX_MISS_E = `CMD_NS_TX_MISS,
    CMD_NS_FIFO_E    = `CMD_NS_FIFO_OVF,
    CMD_NS_TYPE1_E   = `CMD_NS_TYPE1
  } cmd_node_state_e;

  // One list entry write: position and node address
  typedef struct packed {
    logic [6:0]  idx;
    logic [15:0] node;
  } cmd_list_wr_s;

  // One node state update: slave position and new code
  typedef struct packed {
    logic [6:0]      idx;
    cmd_node_state_e code;
  } cmd_ns_wr_s;

endpackage

// ===== rtl/cmd_diag_status.sv
// Diagnostic status bank of the CANopen master, Wishbone register slave
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "cmd_map.svh"
module cmd_diag_status
  import cmd_pkg::*;
#(
  parameter int MAX_CFG = `CMD_MAX_CFG,
  parameter int MAX_DET = `CMD_MAX_DET
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone classic slave
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [11:0]  adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic              ack_o,
  output logic [31:0]       dat_o,
  // Configuration side
  input  wire logic         own_node_i,
  input  wire logic         cfg_cnt_wr_i,
  input  wire logic [7:0]   cfg_cnt_i,
  input  wire logic         cfg_wr_i,
  input  wire cmd_list_wr_s cfg_wr_data_i,
  // Bus scan results
  input  wire logic         scan_wr_i,
  input  wire cmd_list_wr_s scan_wr_data_i,
  input  wire logic         scan_done_i,
  input  wire logic [7:0]   scan_cnt_i,
  // Protocol engine events
  input  wire logic         sync_sent_i,
  input  wire logic         input_upd_i,
  input  wire logic         cycle_done_i,
  input  wire logic [15:0]  cycle_time_i,
  input  wire logic         bus_off_i,
  input  wire logic         ns_wr_i,
  input  wire cmd_ns_wr_s   ns_wr_data_i,
  // Mapped process data
  output logic              sync_sent_toggle_o,
  output logic              input_update_toggle_o,
  output logic              any_slave_fault_flag_o,
  output logic [15:0]       bus_cycle_counter_o
);

  // Stored lists and node states
  logic [15:0] cfg_list_r [0:MAX_CFG-1];
  logic [15:0] det_list_r [0:MAX_DET-1];
  logic [7:0]  ns_r       [0:MAX_CFG-1];

  logic [7:0]  cfg_cnt_r;
  logic [7:0]  det_cnt_r;
  logic        sync_tgl_r;
  logic        in_tgl_r;
  logic        fault_r;
  logic [15:0] cyc_cnt_r;
  logic [15:0] cyc_time_r;
  logic [7:0]  stat_cnt_r;
  logic [MAX_CFG-1:0] nz_r;

  logic [MAX_CFG-1:0] cfg_mask;
  logic [7:0]  stat_cnt_nxt;
  logic        fault_nxt;
  logic [7:0]  cfg_cnt_nxt;
  logic [7:0]  det_cnt_nxt;
  logic [15:0] cfg_node_nxt;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_nxt;
  logic        bus_req;
  logic [6:0]  rd_idx;
  logic [2:0]  rd_rgn;

  // Write data and byte selects stay unused: every entry is read-only
  assign bus_req = cyc_i && stb_i && !ack_r;
  assign rd_idx  = adr_i[8:2];
  assign rd_rgn  = adr_i[11:9];

  // Count written by configuration, clamped to the list length
  always_comb begin
    if (cfg_cnt_i > 8'(MAX_CFG)) begin
      cfg_cnt_nxt = 8'(MAX_CFG);
    end else begin
      cfg_cnt_nxt = cfg_cnt_i;
    end
  end

  // Own CAN interface always shows address 0 in the first entry
  always_comb begin
    if (own_node_i && cfg_wr_data_i.idx == 7'h00) begin
      cfg_node_nxt = `CMD_OWN_NODE_ADR;
    end else begin
      cfg_node_nxt = cfg_wr_data_i.node;
    end
  end

  // Scan count clamped; with own node there are 126 remotes at most
  always_comb begin
    if (scan_cnt_i > 8'(MAX_DET)) begin
      det_cnt_nxt = 8'(MAX_DET);
    end else begin
      det_cnt_nxt = scan_cnt_i;
    end
  end

  // Configured slave count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_cnt_r <= 8'h00;
    end else if (cfg_cnt_wr_i) begin
      cfg_cnt_r <= cfg_cnt_nxt;
    end
  end

  // Configured address list; only the configuration side writes it
  always_ff @(posedge clk_i) begin
    if (cfg_wr_i && cfg_wr_data_i.idx < 7'(MAX_CFG)) begin
      cfg_list_r[cfg_wr_data_i.idx] <= cfg_node_nxt;
    end
  end

  // Detected list entries arrive during the scan
  always_ff @(posedge clk_i) begin
    if (scan_wr_i && scan_wr_data_i.idx < 7'(MAX_DET)) begin
      det_list_r[scan_wr_data_i.idx] <= scan_wr_data_i.node;
    end
  end

  // Detected count becomes visible only once the scan has finished
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_cnt_r <= 8'h00;
    end else if (scan_done_i) begin
      det_cnt_r <= det_cnt_nxt;
    end
  end

  // Sync transmit toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_tgl_r <= 1'b0;
    end else if (sync_sent_i) begin
      sync_tgl_r <= !sync_tgl_r;
    end
  end

  // Host input refresh toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_tgl_r <= 1'b0;
    end else if (input_upd_i) begin
      in_tgl_r <= !in_tgl_r;
    end
  end

  // Cycle counter wraps at 16 bits; frozen with no slave configured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_cnt_r <= 16'h0000;
    end else if (cycle_done_i && cfg_cnt_r != 8'h00) begin
      cyc_cnt_r <= cyc_cnt_r + 16'h0001;
    end
  end

  // Required cycle time, unit is one ninth of a microsecond
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_time_r <= 16'h0000;
    end else begin
      cyc_time_r <= cycle_time_i;
    end
  end

  // Per-slave node state store, indexed in configuration order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < MAX_CFG; i++) begin
        ns_r[i] <= `CMD_NS_OK;
      end
    end else if (ns_wr_i && ns_wr_data_i.idx < 7'(MAX_CFG)) begin
      ns_r[ns_wr_data_i.idx] <= ns_wr_data_i.code;
    end
  end

  // Mask of positions inside the configured count, and nonzero flags
  genvar g;
  generate
    for (g = 0; g < MAX_CFG; g++) begin : g_slave
      assign cfg_mask[g] = 8'(g) < cfg_cnt_r;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          nz_r[g] <= 1'b0;
        end else if (ns_wr_i && ns_wr_data_i.idx == 7'(g)) begin
          nz_r[g] <= ns_wr_data_i.code != CMD_NS_OK_E;
        end
      end
    end
  endgenerate

  // Number of configured slaves not in the no-error state
  always_comb begin
    stat_cnt_nxt = 8'h00;
    for (int i = 0; i < MAX_CFG; i++) begin
      stat_cnt_nxt = stat_cnt_nxt + {7'h00, nz_r[i] & cfg_mask[i]};
    end
  end

  // Bus-off with any slave configured also raises the fault flag
  assign fault_nxt = (|(nz_r & cfg_mask)) ||
                     (bus_off_i && cfg_cnt_r != 8'h00);

  // Summary flag and counter registered to keep the paths short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_r    <= 1'b0;
      stat_cnt_r <= 8'h00;
    end else begin
      fault_r    <= fault_nxt;
      stat_cnt_r <= stat_cnt_nxt;
    end
  end

  // Read data; entries beyond the current counts read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (rd_rgn)
      `CMD_RGN_SCALAR: begin
        case (rd_idx)
          `CMD_W_CFG_CNT:  rd_nxt[7:0] = cfg_cnt_r;
          `CMD_W_DET_CNT:  rd_nxt[7:0] = det_cnt_r;
          `CMD_W_EXT_CNT:  rd_nxt[7:0] = `CMD_EXT_ENTRIES;
          `CMD_W_DIAG: begin
            rd_nxt[`CMD_B_SYNC_TGL] = sync_tgl_r;
            rd_nxt[`CMD_B_DEV_DIAG] = 1'b0; // Reserved, reads 0
            rd_nxt[`CMD_B_SYNC_ERR] = 1'b0; // Reserved, reads 0
            rd_nxt[`CMD_B_IN_TGL]   = in_tgl_r;
            rd_nxt[`CMD_B_FAULT]    = fault_r;
          end
          `CMD_W_CYC_CNT:  rd_nxt[15:0] = cyc_cnt_r;
          `CMD_W_STAT_CNT: rd_nxt[7:0]  = stat_cnt_r;
          `CMD_W_CYC_TIME: rd_nxt[15:0] = cyc_time_r;
          `CMD_W_NS_CNT:   rd_nxt[7:0]  = cfg_cnt_r;
          default:         rd_nxt = 32'h0000_0000;
        endcase
      end
      `CMD_RGN_CFG: begin
        // Own node entry reads 0 even if written before own_node_i rose
        if (own_node_i && rd_idx == 7'h00 && cfg_cnt_r != 8'h00) begin
          rd_nxt[15:0] = `CMD_OWN_NODE_ADR;
        end else if (8'(rd_idx) < cfg_cnt_r) begin
          rd_nxt[15:0] = cfg_list_r[rd_idx];
        end
      end
      `CMD_RGN_DET: begin
        if (8'(rd_idx) < det_cnt_r) begin
          rd_nxt[15:0] = det_list_r[rd_idx];
        end
      end
      `CMD_RGN_NS: begin
        if (8'(rd_idx) < cfg_cnt_r) begin
          if (bus_off_i) begin
            rd_nxt[7:0] = `CMD_NS_BUS_OFF;
          end else begin
            rd_nxt[7:0] = ns_r[rd_idx];
          end
        end
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Every access is acknowledged one cycle later; writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // Read data captured together with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      dat_r <= rd_nxt;
    end else if (bus_req) begin
      dat_r <= 32'h0000_0000;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // Process data image copies straight from flops
  assign sync_sent_toggle_o     = sync_tgl_r;
  assign input_update_toggle_o  = in_tgl_r;
  assign any_slave_fault_flag_o = fault_r;
  assign bus_cycle_counter_o    = cyc_cnt_r;

endmodule // cmd_diag_status

// ===== dv/cmd_diag_status_checker.sv
// Port-level assertions for the diag status bank
`timescale 1ns/100ps
module cmd_diag_status_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        sync_sent_i,
  input wire logic        sync_sent_toggle_o,
  input wire logic        input_upd_i,
  input wire logic        input_update_toggle_o,
  input wire logic        cycle_done_i,
  input wire logic        cfg_cnt_wr_i,
  input wire logic [7:0]  cfg_cnt_i,
  input wire logic [15:0] bus_cycle_counter_o
);
  logic cfg_any_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of whether any slave is configured, so counting can be judged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_any_r <= 1'b0;
    end else if (cfg_cnt_wr_i) begin
      cfg_any_r <= cfg_cnt_i != 8'h00;
    end
  end
  // A fresh request, and the single-cycle answer it must get
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_ack; ack_o ##1 !ack_o; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  property p_wr_zero; s_req ##0 we_i |=> dat_o == 32'h0; endproperty
  // Read data must not drift between accesses
  property p_hold; !ack_o && !(cyc_i && stb_i) |=> $stable(dat_o);
  endproperty
  property p_sync;
    sync_sent_i |=> sync_sent_toggle_o != $past(sync_sent_toggle_o);
  endproperty
  property p_sync_hold; !sync_sent_i |=> $stable(sync_sent_toggle_o);
  endproperty
  property p_in; input_upd_i |=> $changed(input_update_toggle_o); endproperty
  property p_in_hold; !input_upd_i |=> $stable(input_update_toggle_o);
  endproperty
  // Counting needs a configured slave; without one the value must freeze
  property p_cyc; cycle_done_i && cfg_any_r |=>
    bus_cycle_counter_o == $past(bus_cycle_counter_o) + 16'h1; endproperty
  property p_cyc_off; cycle_done_i && !cfg_any_r |=>
    $stable(bus_cycle_counter_o); endproperty
  property p_cyc_hold; !cycle_done_i |=> $stable(bus_cycle_counter_o);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  a_wr_zero: assert property (p_wr_zero) else $error("write data");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_sync: assert property (p_sync) else $error("sync no flip");
  a_sync_hold: assert property (p_sync_hold) else $error("sync flip");
  a_in: assert property (p_in) else $error("input toggle");
  a_in_hold: assert property (p_in_hold) else $error("input flip");
  a_cyc: assert property (p_cyc) else $error("counter step");
  a_cyc_off: assert property (p_cyc_off) else $error("idle count");
  a_cyc_hold: assert property (p_cyc_hold) else $error("count moved");
endmodule // cmd_diag_status_checker

bind cmd_diag_status cmd_diag_status_checker i_chk (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
  .dat_o(dat_o), .sync_sent_i(sync_sent_i),
  .sync_sent_toggle_o(sync_sent_toggle_o), .input_upd_i(input_upd_i),
  .input_update_toggle_o(input_update_toggle_o),
  .cycle_done_i(cycle_done_i), .cfg_cnt_wr_i(cfg_cnt_wr_i),
  .cfg_cnt_i(cfg_cnt_i), .bus_cycle_counter_o(bus_cycle_counter_o));

// ===== dv/cmd_host_model.sv
// Wishbone classic master standing in for the fieldbus host
`timescale 1ns/100ps
module cmd_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [11:0]      adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // Request held until ack is seen at an edge; no fixed latency assumed
  // Only the bench watchdog may end a wait that never sees ack
  task automatic xfer(input logic w, input logic [11:0] a,
                      output logic [31:0] d);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o} <= {2'h3, w, a, 4'hF};
    dat_o <= 32'hFFFF_FFFF;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    d = dat_i;
    // Released data lines flip so stale values are never trusted
    {cyc_o, stb_o} <= 2'h0;
    dat_o <= ~dat_o;
  endtask
endmodule // cmd_host_model

// ===== dv/test_canopen_master_diag_status.sv
// Self-checking bench for the diag status bank
`timescale 1ns/100ps
module test_canopen_master_diag_status
  import cmd_pkg::*;
;
  logic         clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack;
  logic [11:0]  adr;
  logic [3:0]   sel;
  logic [31:0]  wdat, rdat;
  logic         own = 1'b0, cnt_wr = 1'b0, cfg_wr = 1'b0, scan_wr = 1'b0;
  logic         scan_done = 1'b0, sync = 1'b0, in_upd = 1'b0, bus_off = 1'b0;
  logic         cyc_done = 1'b0, ns_wr = 1'b0, sync_tgl, in_tgl, fault;
  logic [7:0]   cfg_cnt = 8'h0, scan_cnt = 8'h0;
  logic [15:0]  cyc_time = 16'h0, cyc_cnt;
  cmd_list_wr_s cfg_d = '0, scan_d = '0;
  cmd_ns_wr_s   ns_d = '0;
  int           failures = 0, cmp_count = 0;

  always #20 clk_i = ~clk_i;

  cmd_host_model i_cmd_host_model (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));
  cmd_diag_status i_cmd_diag_status (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .ack_o(ack), .dat_o(rdat), .own_node_i(own),
    .cfg_cnt_wr_i(cnt_wr), .cfg_cnt_i(cfg_cnt), .cfg_wr_i(cfg_wr),
    .cfg_wr_data_i(cfg_d), .scan_wr_i(scan_wr), .scan_wr_data_i(scan_d),
    .scan_done_i(scan_done), .scan_cnt_i(scan_cnt), .sync_sent_i(sync),
    .input_upd_i(in_upd), .cycle_done_i(cyc_done), .cycle_time_i(cyc_time),
    .bus_off_i(bus_off), .ns_wr_i(ns_wr), .ns_wr_data_i(ns_d),
    .sync_sent_toggle_o(sync_tgl), .input_update_toggle_o(in_tgl),
    .any_slave_fault_flag_o(fault), .bus_cycle_counter_o(cyc_cnt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_cmd_host_model.xfer(1'b0, a, d);
    chk(d, exp);
  endtask
  // Loads the configured count through a one-cycle pulse
  task automatic set_cnt(input logic [7:0] n);
    {cnt_wr, cfg_cnt} <= {1'b1, n};
    @(posedge clk_i);
    cnt_wr <= 1'b0;
  endtask

  // Oversized counts clamp; own node forces address 0 into entry one
  task automatic t_lists;
    own <= 1'b1;
    {cfg_wr, cfg_d, scan_wr, scan_d} <= {1'b1, 23'h5, 1'b1, 23'h11};
    {scan_done, scan_cnt} <= {1'b1, 8'hFF};
    set_cnt(8'hC8);
    {cfg_d, scan_wr, scan_done} <= {7'h1, 16'h23, 2'h0};
    @(posedge clk_i);
    cfg_wr <= 1'b0;
    rd(12'h000, 32'h7F);
    rd(12'h200, 32'h0);
    rd(12'h204, 32'h23);
    rd(12'h004, 32'h7E);
    rd(12'h400, 32'h11);
    set_cnt(8'h02);
    $display("lists test done");
  endtask

  // Back-to-back events, then counting held off with no slaves
  task automatic t_events;
    {sync, cyc_done, in_upd, cyc_time} <= {3'h7, 16'h1234};
    @(posedge clk_i);
    in_upd <= 1'b0;
    repeat (2) @(posedge clk_i);
    {sync, cyc_done} <= 2'h0;
    @(posedge clk_i);
    chk(sync_tgl, 32'h1);
    chk(in_tgl, 32'h1);
    chk(cyc_cnt, 32'h3);
    rd(12'h018, 32'h1234);
    rd(12'h00C, 32'h9);
    set_cnt(8'h00);
    cyc_done <= 1'b1;
    @(posedge clk_i);
    cyc_done <= 1'b0;
    @(posedge clk_i);
    chk(cyc_cnt, 32'h3);
    set_cnt(8'h02);
    $display("events test done");
  endtask

  // Every node state code, bus-off override, then fault clears
  task automatic t_states;
    cmd_node_state_e c;
    c = c.first();
    do begin
      {ns_wr, ns_d} <= {1'b1, 7'h1, c};
      @(posedge clk_i);
      ns_wr <= 1'b0;
      rd(12'h604, {24'h0, c});
      chk(fault, c != CMD_NS_OK_E);
      c = c.next();
    end while (c != c.first());
    rd(12'h014, 32'h1);
    bus_off <= 1'b1;
    rd(12'h600, 32'h0B);
    {bus_off, ns_wr, ns_d} <= {2'h1, 7'h1, CMD_NS_OK_E};
    @(posedge clk_i);
    ns_wr <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(fault, 32'h0);
    $display("states test done");
  endtask

  // Host writes acked with no effect; unmapped space reads zero
  task automatic t_ro;
    logic [31:0] d;
    i_cmd_host_model.xfer(1'b1, 12'h000, d);
    chk(d, 32'h0);
    rd(12'h000, 32'h2);
    rd(12'h800, 32'h0);
    $display("read-only test done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_lists;
    t_events;
    t_states;
    t_ro;
    complete_run;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run;
  end
endmodule // test_canopen_master_diag_status
